// ===== pkg/key_port_map.svh
// Offsets, field positions, reset values and timing counts of the key port
`ifndef KEY_PORT_MAP_SVH
`define KEY_PORT_MAP_SVH
`define KP_CTRL_OFS 8'h00
`define KP_STAT_OFS 8'h04
`define KP_IRQ_STAT_OFS 8'h08
`define KP_IRQ_MASK_OFS 8'h0c
`define KP_V2_KEY_OFS 8'h10
`define KP_V1_KEY_LO_OFS 8'h14
`define KP_V1_KEY_HI_OFS 8'h18
`define KP_V1_ST_OFS 8'h20
`define KP_V2_ST_OFS 8'h24
`define KP_CTRL_RESET 32'h0000_0000
`define KP_MASK_RESET 4'h0
`define KP_EV_V1_CHG 0
`define KP_EV_V2_CHG 1
`define KP_EV_KEY_DONE 2
`define KP_EV_STOP 3
`define KP_EV_W 4
`define KP_READ_LAT 1
`endif

// ===== pkg/key_port_pkg.sv
// Types shared by the content-protection key port
`default_nettype none
package key_port_pkg;
  typedef struct packed {
    logic [7:0] v2_index;
    logic [5:0] v1_index;
  } key_read_addr_t;
  typedef struct packed {
    logic [55:0] v1_key;
    logic [31:0] v2_key;
  } key_read_data_t;
  typedef struct packed {
    logic v1_decrypt_active;
    logic v2_decrypt_active;
    logic stream_type;
  } link_status_t;
  typedef enum logic [2:0] {
    KR_IDLE = 3'b001,
    KR_WAIT = 3'b010,
    KR_TAKE = 3'b100
  } key_read_state_t;
endpackage
`default_nettype wire

// ===== src/content_protection_key_port.sv
// Key access, key storage write ports and status of the protection receiver
//
// How it works
// [R01] Key source holds key-pending high until the requested key is readable.
// [R02] Read address: 8-bit newer-version field, separate 6-bit older-version field.
// [R03] Key source returns 32-bit newer and 56-bit older key data.
// [R04] Key read data follows the presented address by exactly one cycle.
// [R05] Key read conduit exists only without internal key management.
// [R06] Older key store port: 7-bit index, 32-bit data, no wait cycles.
// [R07] Key store ports are word addressed; host divides byte address by four.
// [R08] Older key store port present only with key management and older support.
// [R09] Newer key store port present only with key management and newer support.
// [R10] Older-version active output high while stream is older-version encrypted.
// [R11] Newer-version active output high while stream is newer-version encrypted.
// [R12] Stream type output: zero for type 0, one for type 1.
// [R13] Older-version off input keeps older-version protection inactive.
// [R14] Newer-version off input keeps newer-version protection inactive.
// [R15] After changing an off input, host resets core and raises hot-plug.
// [R16] Serial slave pulses stop-detected at end of each protection command.
// [R17] Key data is sampled only after pending falls, one cycle after address.
//
// The register addresses and the Wishbone slave port were decided locally.
`default_nettype none
`include "key_port_map.svh"
module content_protection_key_port
  import key_port_pkg::*;
#(
  parameter bit KEY_MGMT = 1'b0,
  parameter bit V1_SUPPORT = 1'b1,
  parameter bit V2_SUPPORT = 1'b1,
  parameter int V1_DEPTH = 128,
  parameter int V2_DEPTH = 256
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic key_pending_i,
  output key_read_addr_t key_read_addr_o,
  input wire key_read_data_t key_read_data_i,
  input wire logic v1_key_store_write_i,
  input wire logic [6:0] v1_key_store_index_i,
  input wire logic [31:0] v1_key_store_wdata_i,
  input wire logic v2_key_store_write_i,
  input wire logic [7:0] v2_key_store_index_i,
  input wire logic [31:0] v2_key_store_wdata_i,
  input wire logic v1_encrypted_i,
  input wire logic v2_encrypted_i,
  input wire logic stream_type_i,
  output link_status_t link_status_o,
  input wire logic v1_engine_off_i,
  input wire logic v2_engine_off_i,
  input wire logic stop_detected_i
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Pins from other domains: first stage is read only by the second
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] next_sync1;
  logic [6:0] next_sync2;
  logic pend_s, v1_enc_s, v2_enc_s, type_s, v1_off_s, v2_off_s, stop_s;
  always_comb begin
    next_sync1 = {key_pending_i, v1_encrypted_i, v2_encrypted_i, stream_type_i,
                  v1_engine_off_i, v2_engine_off_i, stop_detected_i};
    next_sync2 = sync1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end
  assign {pend_s, v1_enc_s, v2_enc_s, type_s, v1_off_s, v2_off_s, stop_s} = sync2;

  // ---------------------------------------------------------------
  // Key stores
  // ---------------------------------------------------------------
  // Index inputs are already word indices; the host does the divide by four [R07]
  logic [31:0] v1_mem [V1_DEPTH];
  logic [31:0] v2_mem [V2_DEPTH];
  logic v1_store_en, v2_store_en;
  assign v1_store_en = KEY_MGMT && V1_SUPPORT; // [R08]
  assign v2_store_en = KEY_MGMT && V2_SUPPORT; // [R09]
  genvar gi;
  generate
    for (gi = 0; gi < V1_DEPTH; gi++) begin : g_v1
      logic [31:0] next_word;
      always_comb begin
        next_word = v1_mem[gi];
        if (v1_store_en && v1_key_store_write_i && v1_key_store_index_i == 7'(gi)) begin
          next_word = v1_key_store_wdata_i; // [R06]
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) v1_mem[gi] <= 32'h0000_0000;
        else v1_mem[gi] <= next_word;
      end
    end
    for (gi = 0; gi < V2_DEPTH; gi++) begin : g_v2
      logic [31:0] next_word;
      always_comb begin
        next_word = v2_mem[gi];
        if (v2_store_en && v2_key_store_write_i && v2_key_store_index_i == 8'(gi)) begin
          next_word = v2_key_store_wdata_i;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) v2_mem[gi] <= 32'h0000_0000;
        else v2_mem[gi] <= next_word;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus-side registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [`KP_EV_W-1:0] irq_stat, irq_mask;
  logic [55:0] v1_key;
  logic [31:0] v2_key;
  logic ack;
  logic [31:0] rdata;
  logic [31:0] next_ctrl, next_rdata;
  logic [`KP_EV_W-1:0] next_irq_stat, next_irq_mask, events;
  logic next_ack;
  logic bus_req, wr, rd;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack;
  assign wr = bus_req && wb_we_i;
  assign rd = bus_req && !wb_we_i;

  // ---------------------------------------------------------------
  // Key read machine
  // ---------------------------------------------------------------
  // ctrl[0] starts a read, ctrl[15:8] newer index, ctrl[21:16] older index
  key_read_state_t st, next_st;
  key_read_addr_t raddr, next_raddr;
  logic [55:0] next_v1_key;
  logic [31:0] next_v2_key;
  logic key_done;
  always_comb begin
    next_st = st;
    next_raddr = raddr;
    next_v1_key = v1_key;
    next_v2_key = v2_key;
    key_done = 1'b0;
    case (st)
      KR_IDLE: begin
        if (ctrl[0] && !KEY_MGMT) begin
          next_raddr.v2_index = ctrl[15:8]; // [R02]
          next_raddr.v1_index = ctrl[21:16];
          next_st = KR_WAIT;
        end
      end
      KR_WAIT: begin
        if (!pend_s) next_st = KR_TAKE; // [R01] [R17]
      end
      KR_TAKE: begin
        // Address has stood at least one cycle before this take [R04]
        next_v2_key = key_read_data_i.v2_key; // [R03]
        next_v1_key = key_read_data_i.v1_key;
        key_done = 1'b1;
        next_st = KR_IDLE;
      end
      default: next_st = KR_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st <= KR_IDLE;
      raddr <= '0;
      v1_key <= 56'h0;
      v2_key <= 32'h0;
    end else begin
      st <= next_st;
      raddr <= next_raddr;
      v1_key <= next_v1_key;
      v2_key <= next_v2_key;
    end
  end
  // Conduit is tied off when keys are managed internally [R05]
  assign key_read_addr_o = KEY_MGMT ? '0 : raddr;

  // ---------------------------------------------------------------
  // Status and interrupts
  // ---------------------------------------------------------------
  logic v1_off_q, v2_off_q;
  link_status_t status, next_status;
  always_comb begin
    next_status.v1_decrypt_active = v1_enc_s && !v1_off_s && V1_SUPPORT; // [R10] [R13]
    next_status.v2_decrypt_active = v2_enc_s && !v2_off_s && V2_SUPPORT; // [R11] [R14]
    next_status.stream_type = type_s; // [R12]
    events = '0;
    events[`KP_EV_V1_CHG] = v1_off_s ^ v1_off_q; // Host must reset core after this [R15]
    events[`KP_EV_V2_CHG] = v2_off_s ^ v2_off_q;
    events[`KP_EV_KEY_DONE] = key_done;
    events[`KP_EV_STOP] = stop_s; // [R16]
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      status <= '0;
      v1_off_q <= 1'b0;
      v2_off_q <= 1'b0;
    end else begin
      status <= next_status;
      v1_off_q <= v1_off_s;
      v2_off_q <= v2_off_s;
    end
  end
  assign link_status_o = status;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // One-cycle ack; a read of the interrupt status register clears it, new events win
  always_comb begin
    next_ctrl = ctrl;
    next_ctrl[0] = 1'b0;
    next_irq_mask = irq_mask;
    next_ack = bus_req;
    next_rdata = rdata;
    next_irq_stat = irq_stat;
    if (wr && wb_adr_i == `KP_CTRL_OFS) begin
      if (wb_sel_i[0]) next_ctrl[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_ctrl[15:8] = wb_dat_i[15:8];
      if (wb_sel_i[2]) next_ctrl[23:16] = wb_dat_i[23:16];
      if (wb_sel_i[3]) next_ctrl[31:24] = wb_dat_i[31:24];
    end
    if (wr && wb_adr_i == `KP_IRQ_MASK_OFS && wb_sel_i[0]) begin
      next_irq_mask = wb_dat_i[`KP_EV_W-1:0];
    end
    if (rd) begin
      case (wb_adr_i)
        `KP_CTRL_OFS: next_rdata = {ctrl[31:1], 1'b0};
        `KP_STAT_OFS: next_rdata = {26'h0, st != KR_IDLE, v1_off_s, v2_off_s,
                                   status.v1_decrypt_active, status.v2_decrypt_active,
                                   status.stream_type};
        `KP_IRQ_STAT_OFS: begin
          next_rdata = {28'h0, irq_stat};
          next_irq_stat = '0;
        end
        `KP_IRQ_MASK_OFS: next_rdata = {28'h0, irq_mask};
        `KP_V2_KEY_OFS: next_rdata = v2_key;
        `KP_V1_KEY_LO_OFS: next_rdata = v1_key[31:0];
        `KP_V1_KEY_HI_OFS: next_rdata = {8'h00, v1_key[55:32]};
        `KP_V1_ST_OFS: next_rdata = v1_mem[ctrl[30:24]];
        `KP_V2_ST_OFS: next_rdata = v2_mem[ctrl[15:8]];
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq_stat = next_irq_stat | events;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl <= `KP_CTRL_RESET;
      irq_mask <= `KP_MASK_RESET;
      irq_stat <= '0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign irq_o = |(irq_stat & irq_mask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_start;
    st == KR_IDLE && ctrl[0] && !KEY_MGMT;
  endsequence
  property p_addr_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      s_start |=> (raddr.v2_index == $past(ctrl[15:8]) && st == KR_WAIT);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("index not latched"); // [R02]
  property p_wait_pending;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st == KR_WAIT && pend_s) |=> st == KR_WAIT;
  endproperty
  a_wait_pending: assert property (p_wait_pending) else $error("left wait early"); // [R01]
  property p_take;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      st == KR_TAKE |=> (v2_key == $past(key_read_data_i.v2_key) && st == KR_IDLE);
  endproperty
  a_take: assert property (p_take) else $error("key not taken"); // [R17]
  property p_v1_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      v1_off_s |=> !status.v1_decrypt_active;
  endproperty
  a_v1_off: assert property (p_v1_off) else $error("older active while off"); // [R13]
  property p_v2_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      v2_off_s |=> !status.v2_decrypt_active;
  endproperty
  a_v2_off: assert property (p_v2_off) else $error("newer active while off"); // [R14]
  property p_v1_act;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (v1_enc_s && !v1_off_s && V1_SUPPORT) |=> status.v1_decrypt_active;
  endproperty
  a_v1_act: assert property (p_v1_act) else $error("older active missing"); // [R10]
  property p_v2_act;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (v2_enc_s && !v2_off_s && V2_SUPPORT) |=> status.v2_decrypt_active;
  endproperty
  a_v2_act: assert property (p_v2_act) else $error("newer active missing"); // [R11]
  property p_type;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      1'b1 |=> status.stream_type == $past(type_s);
  endproperty
  a_type: assert property (p_type) else $error("stream type wrong"); // [R12]
  property p_v1_store;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (v1_store_en && v1_key_store_write_i) |=>
        v1_mem[$past(v1_key_store_index_i)] == $past(v1_key_store_wdata_i);
  endproperty
  a_v1_store: assert property (p_v1_store) else $error("older store write lost"); // [R06]
  property p_ack;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ack |=> !ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ===== test/content_protection_key_port_tb.sv
// Self-checking bench for the content-protection key port
`default_nettype none
`include "key_port_map.svh"
module content_protection_key_port_tb;
  import key_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, cyc, stb, we, ack, irq, pend, slow, stop;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  key_read_addr_t kaddr;
  key_read_data_t kdata;
  logic v1w, v2w, v1e, v2e, st, v1off, v2off;
  logic [6:0] v1i;
  logic [7:0] v2i;
  logic [31:0] v1d, v2d;
  link_status_t ls;
  int err_count, compares, cycles;
  content_protection_key_port uut (.sys_clk_i(sys_clk), .rstn_i(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .key_pending_i(pend),
    .key_read_addr_o(kaddr), .key_read_data_i(kdata), .v1_key_store_write_i(v1w),
    .v1_key_store_index_i(v1i), .v1_key_store_wdata_i(v1d), .v2_key_store_write_i(v2w),
    .v2_key_store_index_i(v2i), .v2_key_store_wdata_i(v2d), .v1_encrypted_i(v1e),
    .v2_encrypted_i(v2e), .stream_type_i(st), .link_status_o(ls), .v1_engine_off_i(v1off),
    .v2_engine_off_i(v2off), .stop_detected_i(stop));
  key_source_model ksrc (.clk_i(sys_clk), .rstn_i(rstn), .slow_i(slow), .addr_i(kaddr),
    .pending_o(pend), .data_o(kdata));
  always #2 sys_clk = ~sys_clk;
  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Classic cycle: hold everything until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    // Look at ack and data mid-cycle, where the registered outputs have settled
    do begin
      @(negedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    if (n >= 64) err_count++;
    @(posedge sys_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, `KP_CTRL_OFS, 32'h0, q);
    chk("ctrl", q, `KP_CTRL_RESET);
    wb(1'b0, `KP_IRQ_MASK_OFS, 32'h0, q);
    chk("mask", q[3:0], `KP_MASK_RESET);
    wb(1'b1, 8'h40, 32'hffff_ffff, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("irq", irq, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_key(input logic [7:0] i2, input logic [5:0] i1, input logic s);
    logic [31:0] q;
    int n;
    slow <= s;
    wb(1'b1, `KP_CTRL_OFS, {10'h0, i1, i2, 8'h01}, q);
    n = 0;
    q = 32'h20;
    while (q[5] !== 1'b0 && n < 40) begin
      wb(1'b0, `KP_STAT_OFS, 32'h0, q);
      n++;
    end
    chk("read addr", kaddr, {i2, i1});
    wb(1'b0, `KP_V2_KEY_OFS, 32'h0, q);
    chk("v2 key", q, {i2, ~i2, i2 ^ 8'h3c, 8'h5a});
    wb(1'b0, `KP_V1_KEY_LO_OFS, 32'h0, q);
    chk("v1 key lo", q, {4{2'b10, i1}});
    wb(1'b0, `KP_V1_KEY_HI_OFS, 32'h0, q);
    chk("v1 key hi", q[23:0], {3{2'b10, i1}});
    wb(1'b0, `KP_IRQ_STAT_OFS, 32'h0, q);
    chk("key done", q[2], 1'b1);
    $display("test key read done");
  endtask
  task automatic t_status;
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      {v1e, v2e, st} <= i[2:0];
      tick(5);
      chk("link status", ls, i[2:0]);
    end
    {v1off, v2off} <= 2'b10;
    tick(5);
    chk("v1 off", ls, 3'b011);
    {v1off, v2off} <= 2'b01;
    tick(5);
    chk("v2 off", ls, 3'b101);
    wb(1'b0, `KP_STAT_OFS, 32'h0, q);
    chk("stat off", q[4:0], 5'b01101);
    wb(1'b0, `KP_IRQ_STAT_OFS, 32'h0, q);
    chk("off flags", q[1:0], 2'b11);
    wb(1'b0, `KP_IRQ_STAT_OFS, 32'h0, q);
    chk("off cleared", q[1:0], 2'b00);
    {v1off, v2off, v1e, v2e, st} <= 5'h0;
    tick(5);
    $display("test status done");
  endtask
  task automatic t_irq;
    logic [31:0] q;
    wb(1'b1, `KP_IRQ_MASK_OFS, 32'h8, q);
    for (int m = 1; m >= 0; m--) begin
      stop <= 1'b1;
      tick(1);
      stop <= 1'b0;
      tick(5);
      chk("irq level", irq, m[0]);
      wb(1'b0, `KP_IRQ_STAT_OFS, 32'h0, q);
      chk("stop flag", q[3], 1'b1);
      tick(2);
      chk("irq cleared", irq, 1'b0);
      wb(1'b1, `KP_IRQ_MASK_OFS, 32'h0, q);
    end
    $display("test interrupt done");
  endtask
  task automatic t_store;
    logic [31:0] q;
    {v1w, v2w} <= 2'b11;
    v1i <= 7'h05;
    v1d <= 32'hdead_beef;
    v2i <= 8'h09;
    v2d <= 32'h1357_9bdf;
    tick(1);
    {v1w, v2w} <= 2'b00;
    wb(1'b1, `KP_CTRL_OFS, {1'b0, 7'h05, 16'h0009, 8'h00}, q);
    wb(1'b0, `KP_V1_ST_OFS, 32'h0, q);
    chk("v1 store absent", q === 32'hdead_beef, 1'b0);
    wb(1'b0, `KP_V2_ST_OFS, 32'h0, q);
    chk("v2 store absent", q === 32'h1357_9bdf, 1'b0);
    $display("test key store done");
  endtask
  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    {sys_clk, rstn, cyc, stb, we, slow, stop, v1w, v2w} = '0;
    {v1e, v2e, st, v1off, v2off, adr, sel, wdat, v1i, v2i, v1d, v2d} = '0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_key(8'ha5, 6'h2c, 1'b0);
    t_key(8'h3e, 6'h13, 1'b1);
    t_status;
    t_irq;
    t_store;
    stop_test;
  end
endmodule
`default_nettype wire

// ===== test/key_source_model.sv
// Behavioural key memory that raises a pending flag until a key is readable
`default_nettype none
module key_source_model
  import key_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire key_read_addr_t addr_i,
  output logic pending_o,
  output key_read_data_t data_o
);
  key_read_addr_t last;
  key_read_data_t ready;
  logic [3:0] wait_c;
  logic [3:0] open_c;
  // -------------------------------------------------------------------------
  // Key lookup and ready window
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    last <= addr_i;
    ready.v2_key <= {addr_i.v2_index, ~addr_i.v2_index, addr_i.v2_index ^ 8'h3c, 8'h5a};
    ready.v1_key <= {7{2'b10, addr_i.v1_index}};
    if (!rstn_i) begin
      wait_c <= 4'h0;
      open_c <= 4'h0;
    end else if (addr_i != last) begin
      wait_c <= slow_i ? 4'hc : 4'h1;
      open_c <= 4'h0;
    end else if (wait_c != 4'h0) begin
      wait_c <= wait_c - 4'h1;
      if (wait_c == 4'h1) open_c <= 4'h6;
    end else if (open_c != 4'h0) begin
      open_c <= open_c - 4'h1;
    end
  end
  // High except in the short window where the key may be taken
  assign pending_o = (open_c == 4'h0);
  // Inverted outside the window so an early or late sample is caught
  assign data_o = pending_o ? ~ready : ready;
endmodule
`default_nettype wire
